// *** hw/bcs_pkg.sv ***
package bcs_pkg;
    // Option codes the port answers to
    localparam logic [2:0] OPT_WORD  = 3'h0;
    localparam logic [2:0] OPT_BYTE  = 3'h1;
    localparam logic [2:0] OPT_HALF  = 3'h2;
    // Address space codes
    localparam logic [1:0] DSPACE_MEM = 2'h0;
    localparam logic       ISPACE_MEM = 1'b0;
    // Block decode: upper address bits compared against the base
    localparam int BASE_MSB = 31;
    localparam int BASE_LSB = 24;
    localparam int BASE_W   = BASE_MSB - BASE_LSB + 1;
    // Reset values
    localparam logic [BASE_W-1:0] BASE_RST = 8'h00;
    localparam logic [31:0]       ADDR_RST = 32'h0000_0000;
    // Wait count loaded at acceptance; ready comes one clock after it runs out
    localparam logic [1:0] ACC_LAT = 2'h1;
    // Idle clocks after an access while the synchronisers still show it
    localparam logic [1:0] SYNC_HOLD = 2'h2;
    // Word step of generated burst addresses
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;

    typedef enum {ST_IDLE, ST_WAIT, ST_DONE} bcs_state_t;

    // One channel's access request as seen by the port
    typedef struct packed {
        logic        req;
        logic        burst;
        logic        pipe;
        logic        write;
        logic [31:0] addr;
    } bcs_req_t;

    // Active-low three-state response set
    typedef struct packed {
        logic done_n;
        logic done_oe_n;
        logic grant_n;
        logic grant_oe_n;
    } bcs_rsp_t;
endpackage : bcs_pkg

// *** hw/bcs_port.sv ***
module bcs_port
    import bcs_pkg::*;
(
    input  wire logic              CLK,                    // System clock
    input  wire logic              RESET,                  // Async reset, high
    input  wire logic [31:0]       ADDR,                   // Byte address
    input  wire logic              BUS_NOT_VALID_N,        // Low: bus invalid
    input  wire logic              READ_NOT_WRITE,         // High read
    input  wire logic              DATA_ACCESS_REQ_N,      // Data request
    input  wire logic [1:0]        DATA_SPACE_TYPE,        // Data space
    input  wire logic [2:0]        TRANSFER_OPTION_CODE,   // Size and mode
    input  wire logic              DATA_BURST_ASK_N,       // Data burst ask
    input  wire logic              PIPELINED_DATA_ADDR_N,  // Data pipelined
    input  wire logic              INSTR_ACCESS_REQ_N,     // Instr request
    input  wire logic              INSTR_SPACE_TYPE,       // Instr space
    input  wire logic              INSTR_BURST_ASK_N,      // Instr burst ask
    input  wire logic              PIPELINED_INSTR_ADDR_N, // Instr pipelined
    input  wire logic              CFG_LOAD,               // Config strobe
    input  wire logic [BASE_W-1:0] CFG_BASE,               // Block base
    output logic                   DATA_DONE_N,            // Data ready
    output logic                   DATA_DONE_OE_N,         // Enable, low
    output logic                   DATA_BURST_GRANT_N,     // Data burst ack
    output logic                   DATA_BURST_GRANT_OE_N,  // Enable, low
    output logic                   INSTR_DONE_N,           // Instr ready
    output logic                   INSTR_DONE_OE_N,        // Enable, low
    output logic                   INSTR_BURST_GRANT_N,    // Instr burst ack
    output logic                   INSTR_BURST_GRANT_OE_N, // Enable, low
    output logic                   PIPELINE_ACCEPT_N,      // Pipeline enable
    output logic                   PIPELINE_ACCEPT_OE_N,   // Enable, low
    output logic                   RESET_CHAIN_OUT_N,      // Reset chain
    output logic [31:0]            ACC_ADDR,               // Current address
    output logic                   ACC_WRITE,              // Current is write
    output logic                   ACC_IS_DATA             // Current is data
);

    // Own-block decode of an address
    function automatic logic hits_block(input logic [31:0] a,
                                        input logic [BASE_W-1:0] b);
        hits_block = (a[BASE_MSB:BASE_LSB] == b);
    endfunction

    // Input synchronisers (pins are outside the clock domain)
    localparam int SW = 32 + 1 + 1 + 1 + 2 + 3 + 1 + 1 + 1 + 1 + 1 + 1
                        + 1 + BASE_W;
    logic [SW-1:0] sy1_ff;
    logic [SW-1:0] sy2_ff;
    logic [SW-1:0] pins;
    assign pins = {ADDR, BUS_NOT_VALID_N, READ_NOT_WRITE,
                   DATA_ACCESS_REQ_N, DATA_SPACE_TYPE,
                   TRANSFER_OPTION_CODE, DATA_BURST_ASK_N,
                   PIPELINED_DATA_ADDR_N, INSTR_ACCESS_REQ_N,
                   INSTR_SPACE_TYPE, INSTR_BURST_ASK_N,
                   PIPELINED_INSTR_ADDR_N, CFG_LOAD, CFG_BASE};

    // Two-flop capture on rising edge
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            sy1_ff <= '0;
            sy2_ff <= '0;
        end else begin
            sy1_ff <= pins;
            sy2_ff <= sy1_ff;
        end
    end

    logic [31:0]       s_addr;
    logic              s_valid_n, s_rnw, s_data_access_req_n_n, s_dburst_n, s_dpipe_n;
    logic [1:0]        s_dtype;
    logic [2:0]        s_opt;
    logic              s_instr_access_req_n_n, s_itype, s_iburst_n, s_ipipe_n, s_cfg;
    logic [BASE_W-1:0] s_base;
    assign {s_addr, s_valid_n, s_rnw, s_data_access_req_n_n, s_dtype, s_opt,
            s_dburst_n, s_dpipe_n, s_instr_access_req_n_n, s_itype, s_iburst_n,
            s_ipipe_n, s_cfg, s_base} = sy2_ff;

    // Configuration state
    logic              cfg_done_ff, nxt_cfg_done;
    logic [BASE_W-1:0] base_ff, nxt_base;

    always_comb begin
        nxt_cfg_done = cfg_done_ff;
        nxt_base     = base_ff;
        if (s_cfg) begin
            nxt_cfg_done = 1'b1;
            nxt_base     = s_base;
        end
    end

    // Reset clears configuration
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            cfg_done_ff <= 1'b0;
            base_ff     <= BASE_RST;
        end else begin
            cfg_done_ff <= nxt_cfg_done;
            base_ff     <= nxt_base;
        end
    end

    // Chain output low in reset and until configured
    assign RESET_CHAIN_OUT_N = cfg_done_ff;

    // Request qualification
    logic opt_ok, d_hit, i_hit;
    assign opt_ok = (s_opt == OPT_WORD) || (s_opt == OPT_BYTE)
                    || (s_opt == OPT_HALF);
    assign d_hit = cfg_done_ff && s_valid_n && !s_data_access_req_n_n
                   && (s_dtype == DSPACE_MEM) && opt_ok
                   && hits_block(s_addr, base_ff);
    assign i_hit = cfg_done_ff && s_valid_n && !s_instr_access_req_n_n
                   && (s_itype == ISPACE_MEM)
                   && hits_block(s_addr, base_ff);

    // Access engine state
    bcs_state_t  st_ff, nxt_st;
    logic [1:0]  cnt_ff, nxt_cnt;
    logic [31:0] addr_ff, nxt_addr;
    logic        wr_ff, nxt_wr, dat_ff, nxt_dat, burst_ff, nxt_burst;
    logic        pend_ff, nxt_pend;
    logic [1:0]  hold_ff, nxt_hold;
    logic [31:0] pend_addr_ff, nxt_pend_addr;
    logic        pend_dat_ff, nxt_pend_dat, pend_wr_ff, nxt_pend_wr;
    bcs_rsp_t    drsp_ff, nxt_drsp, irsp_ff, nxt_irsp;
    logic        pen_ff, nxt_pen, pen_oe_ff, nxt_pen_oe;
    logic        ask_n;

    assign ask_n = dat_ff ? s_dburst_n : s_iburst_n;

    always_comb begin
        nxt_st        = st_ff;
        nxt_cnt       = cnt_ff;
        nxt_addr      = addr_ff;
        nxt_wr        = wr_ff;
        nxt_dat       = dat_ff;
        nxt_burst     = burst_ff;
        nxt_pend      = pend_ff;
        nxt_pend_addr = pend_addr_ff;
        nxt_pend_dat  = pend_dat_ff;
        nxt_pend_wr   = pend_wr_ff;
        // Stale request still in the synchronisers after an access
        nxt_hold      = (hold_ff == 2'h0) ? 2'h0 : 2'(hold_ff - 2'h1);
        nxt_drsp      = '{done_n: 1'b1, done_oe_n: 1'b1,
                          grant_n: 1'b1, grant_oe_n: 1'b1};
        nxt_irsp      = nxt_drsp;
        nxt_pen       = 1'b1;
        nxt_pen_oe    = 1'b1;
        case (st_ff)
            ST_IDLE: begin
                if (pend_ff || ((d_hit || i_hit) && hold_ff == 2'h0)) begin
                    nxt_st   = ST_WAIT;
                    nxt_cnt  = ACC_LAT;
                    nxt_pend = 1'b0;
                    if (pend_ff) begin
                        nxt_addr = pend_addr_ff;
                        nxt_dat  = pend_dat_ff;
                        nxt_wr   = pend_wr_ff;
                    end else begin
                        nxt_addr = s_addr;
                        nxt_dat  = d_hit;  // Data wins over instruction
                        nxt_wr   = d_hit && !s_rnw;
                    end
                end
            end
            ST_WAIT: begin
                // Claim the bus lines for our block
                nxt_pen_oe = 1'b0;
                nxt_pen    = pend_ff;
                if (dat_ff) begin
                    nxt_drsp.done_oe_n  = 1'b0;
                    nxt_drsp.grant_oe_n = 1'b0;
                    nxt_drsp.grant_n    = ask_n;
                end else begin
                    nxt_irsp.done_oe_n  = 1'b0;
                    nxt_irsp.grant_oe_n = 1'b0;
                    nxt_irsp.grant_n    = ask_n;
                end
                nxt_burst = !ask_n;
                // Capture an early next address
                // Only a new address counts; the held one is current
                if (!pend_ff && !s_dpipe_n && d_hit
                    && s_addr != addr_ff) begin
                    nxt_pend      = 1'b1;
                    nxt_pend_addr = s_addr;
                    nxt_pend_dat  = 1'b1;
                    nxt_pend_wr   = !s_rnw;
                end else if (!pend_ff && !s_ipipe_n && i_hit
                             && s_addr != addr_ff) begin
                    nxt_pend      = 1'b1;
                    nxt_pend_addr = s_addr;
                    nxt_pend_dat  = 1'b0;
                    nxt_pend_wr   = 1'b0;
                end
                if (cnt_ff == 2'h0) begin
                    nxt_st = ST_DONE;
                    if (dat_ff) nxt_drsp.done_n = 1'b0;
                    else        nxt_irsp.done_n = 1'b0;
                end else begin
                    nxt_cnt = 2'(cnt_ff - 2'h1);
                end
            end
            ST_DONE: begin
                if (burst_ff && !ask_n) begin
                    // Burst continues at the next word
                    nxt_addr = 32'(addr_ff + WORD_STEP);
                    nxt_cnt  = ACC_LAT;
                    nxt_st   = ST_WAIT;
                end else begin
                    nxt_burst = 1'b0;
                    nxt_st    = ST_IDLE;
                    nxt_hold  = SYNC_HOLD; // Ignore the lagging request
                end
            end
            default: nxt_st = ST_IDLE;
        endcase
    end

    // Engine registers
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            st_ff        <= ST_IDLE;
            cnt_ff       <= 2'h0;
            addr_ff      <= ADDR_RST;
            wr_ff        <= 1'b0;
            dat_ff       <= 1'b0;
            burst_ff     <= 1'b0;
            pend_ff      <= 1'b0;
            pend_addr_ff <= ADDR_RST;
            pend_dat_ff  <= 1'b0;
            pend_wr_ff   <= 1'b0;
            drsp_ff      <= '1;
            irsp_ff      <= '1;
            pen_ff       <= 1'b1;
            pen_oe_ff    <= 1'b1;
            hold_ff      <= 2'h0;
        end else begin
            st_ff        <= nxt_st;
            cnt_ff       <= nxt_cnt;
            addr_ff      <= nxt_addr;
            wr_ff        <= nxt_wr;
            dat_ff       <= nxt_dat;
            burst_ff     <= nxt_burst;
            pend_ff      <= nxt_pend;
            pend_addr_ff <= nxt_pend_addr;
            pend_dat_ff  <= nxt_pend_dat;
            pend_wr_ff   <= nxt_pend_wr;
            drsp_ff      <= nxt_drsp;
            irsp_ff      <= nxt_irsp;
            pen_ff       <= nxt_pen;
            pen_oe_ff    <= nxt_pen_oe;
            hold_ff      <= nxt_hold;
        end
    end

    // Output mapping
    assign DATA_DONE_N            = drsp_ff.done_n;
    assign DATA_DONE_OE_N         = drsp_ff.done_oe_n;
    assign DATA_BURST_GRANT_N     = drsp_ff.grant_n;
    assign DATA_BURST_GRANT_OE_N  = drsp_ff.grant_oe_n;
    assign INSTR_DONE_N           = irsp_ff.done_n;
    assign INSTR_DONE_OE_N        = irsp_ff.done_oe_n;
    assign INSTR_BURST_GRANT_N    = irsp_ff.grant_n;
    assign INSTR_BURST_GRANT_OE_N = irsp_ff.grant_oe_n;
    assign PIPELINE_ACCEPT_N      = pen_ff;
    assign PIPELINE_ACCEPT_OE_N   = pen_oe_ff;
    assign ACC_ADDR               = addr_ff;
    assign ACC_WRITE              = wr_ff;
    assign ACC_IS_DATA            = dat_ff;

    // Chain output follows configuration
    property p_chain;
        @(posedge CLK) disable iff (RESET)
        !RESET_CHAIN_OUT_N && !s_cfg |=> !RESET_CHAIN_OUT_N;
    endproperty
    a_chain: assert property (p_chain)
        else $error("reset chain released before configuration");

    // No answer without configuration
    property p_unconf;
        @(posedge CLK) disable iff (RESET)
        !cfg_done_ff |-> DATA_DONE_OE_N && INSTR_DONE_OE_N;
    endproperty
    a_unconf: assert property (p_unconf)
        else $error("response driven while unconfigured");

    // Invalid bus never starts an access
    property p_invalid;
        @(posedge CLK) disable iff (RESET)
        (st_ff == ST_IDLE && !pend_ff && !s_valid_n) |=> st_ff == ST_IDLE;
    endproperty
    a_invalid: assert property (p_invalid)
        else $error("access started on invalid bus");

    // Bad option never starts a data access
    property p_opt;
        @(posedge CLK) disable iff (RESET)
        (st_ff == ST_IDLE && !pend_ff && s_instr_access_req_n_n && s_opt > OPT_HALF)
        |=> st_ff == ST_IDLE;
    endproperty
    a_opt: assert property (p_opt)
        else $error("data access on unsupported option");

    // Data space must be zero
    property p_dspace;
        @(posedge CLK) disable iff (RESET)
        (st_ff == ST_IDLE && !pend_ff && s_instr_access_req_n_n && s_dtype != DSPACE_MEM)
        |=> st_ff == ST_IDLE;
    endproperty
    a_dspace: assert property (p_dspace)
        else $error("data access on foreign space");

    // Instruction space must be zero
    property p_ispace;
        @(posedge CLK) disable iff (RESET)
        (st_ff == ST_IDLE && !pend_ff && s_data_access_req_n_n && s_itype)
        |=> st_ff == ST_IDLE;
    endproperty
    a_ispace: assert property (p_ispace)
        else $error("instruction access on foreign space");

    // Accepted access finishes with a ready pulse
    sequence s_start;
        st_ff == ST_IDLE ##1 st_ff == ST_WAIT;
    endsequence
    property p_ready;
        @(posedge CLK) disable iff (RESET)
        s_start |-> ##[1:3] (!DATA_DONE_N || !INSTR_DONE_N);
    endproperty
    a_ready: assert property (p_ready)
        else $error("ready missing after access");

    // Data ready is a single-cycle pulse
    property p_pulse;
        @(posedge CLK) disable iff (RESET)
        !DATA_DONE_N |=> DATA_DONE_N;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("data ready held too long");

    // Burst steps the address by one word
    property p_step;
        @(posedge CLK) disable iff (RESET)
        (st_ff == ST_DONE && burst_ff && !ask_n)
        |=> addr_ff == 32'($past(addr_ff) + WORD_STEP);
    endproperty
    a_step: assert property (p_step)
        else $error("burst address not stepped");

    // Instruction ready only on instruction accesses
    property p_iready;
        @(posedge CLK) disable iff (RESET)
        !INSTR_DONE_N |-> !INSTR_DONE_OE_N && !dat_ff;
    endproperty
    a_iready: assert property (p_iready)
        else $error("instruction ready on wrong access");

endmodule // bcs_port

// *** bench/bcs_cpu_model.sv ***
// Processor channel master: holds each request until its last done is sampled or it times out
module bcs_cpu_model
    import bcs_pkg::*;
(
    input  wire logic        clk,     // System clock
    input  wire logic        rst,     // Reset, high
    input  wire logic        go,      // Start an access
    input  wire bcs_req_t    cmd,     // Access to make
    input  wire logic        is_data, // Data channel when high
    input  wire logic [2:0]  opt,     // Option code
    input  wire logic [1:0]  space,   // Space type
    input  wire logic        bad_bus, // Mark bus invalid
    input  wire logic [3:0]  words,   // Words to move
    input  wire logic        ddone_n, // Data done
    input  wire logic        idone_n, // Instr done
    output logic [31:0]      addr,    // Byte address
    output logic             bnv_n,   // Bus valid when high
    output logic             rnw,     // Read high
    output logic             data_access_req_n_n,  // Data request
    output logic [1:0]       dtype,   // Data space
    output logic [2:0]       optc,    // Option code
    output logic             dask_n,  // Data burst ask
    output logic             dpipe_n, // Data pipelined
    output logic             instr_access_req_n_n,  // Instr request
    output logic             itype,   // Instr space
    output logic             iask_n,  // Instr burst ask
    output logic             ipipe_n, // Instr pipelined
    output logic             busy     // Access in flight
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       is_d, pip;
    logic [3:0] left;
    logic [4:0] tmo;

    // Drop the request and mark the bus invalid
    task automatic drop();
        busy    <= 1'b0;
        data_access_req_n_n  <= 1'b1;
        instr_access_req_n_n  <= 1'b1;
        dask_n  <= 1'b1;
        iask_n  <= 1'b1;
        dpipe_n <= 1'b1;
        ipipe_n <= 1'b1;
        bnv_n   <= 1'b0;
    endtask

    // Request sequencing on the rising edge
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            drop();
            addr  <= 32'h5A5A_5A5A;
            rnw   <= 1'b1;
            dtype <= 2'h3;
            itype <= 1'b1;
            optc  <= 3'h7;
            left  <= 4'h0;
            tmo   <= 5'h00;
            is_d  <= 1'b0;
            pip   <= 1'b0;
        end else if (!busy) begin
            if (go) begin
                is_d    <= is_data;
                pip     <= cmd.pipe;
                addr    <= cmd.addr;
                rnw     <= !cmd.write;
                bnv_n   <= !bad_bus;
                data_access_req_n_n  <= !is_data;
                instr_access_req_n_n  <= is_data;
                dtype   <= space;
                itype   <= space[0];
                optc    <= opt;
                dask_n  <= !(is_data && cmd.burst);
                iask_n  <= !(!is_data && cmd.burst);
                dpipe_n <= !(is_data && cmd.pipe);
                ipipe_n <= !(!is_data && cmd.pipe);
                left    <= words;
                tmo     <= 5'h00;
                busy    <= 1'b1;
            end else begin
                addr <= ~addr; // Idle bus is not held
            end
        end else begin
            tmo <= tmo + 5'h01;
            if (pip && tmo == 5'h00) begin
                addr <= addr + 32'h0000_0004; // Next address early
            end
            if (!(is_d ? ddone_n : idone_n)) begin
                left <= left - 4'h1;
                if (left == 4'h2) begin
                    dask_n <= 1'b1; // Last word: stop asking
                    iask_n <= 1'b1;
                end
                if (left == 4'h1) begin
                    drop();
                end
            end else if (tmo == 5'h1F) begin
                drop(); // No answer: give up
            end
        end
    end
endmodule // bcs_cpu_model

// *** bench/test_bcs_port.sv ***
// Bench for the channel port
module test_bcs_port
    import bcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic first, more, is_d, wr;
        logic [31:0] addr;
    } bcs_exp_t;
    logic clk, rst, go, is_data, bad_bus, cfg_load, busy;
    logic [2:0] opt;
    logic [1:0] space;
    logic [3:0] words;
    logic [7:0] cfg_base;
    bcs_req_t cmd;
    logic [31:0] addr, acc_addr, rnd;
    logic bnv_n, rnw, data_access_req_n_n, dask_n, dpipe_n, instr_access_req_n_n, itype, iask_n, ipipe_n;
    logic [1:0] dtype;
    logic [2:0] optc;
    logic dd_n, dd_oe_n, dg_n, dg_oe_n, id_n, id_oe_n, ig_n, ig_oe_n;
    logic pa_n, pa_oe_n, rco_n, acc_w, acc_d;
    int failures, cmp_count, cycles;
    bcs_exp_t q[$];

    bcs_cpu_model u_cpu (.clk(clk), .rst(rst), .go(go), .cmd(cmd),
        .is_data(is_data), .opt(opt), .space(space), .bad_bus(bad_bus),
        .words(words), .ddone_n(dd_n), .idone_n(id_n), .addr(addr),
        .bnv_n(bnv_n), .rnw(rnw), .data_access_req_n_n(data_access_req_n_n), .dtype(dtype),
        .optc(optc), .dask_n(dask_n), .dpipe_n(dpipe_n), .instr_access_req_n_n(instr_access_req_n_n),
        .itype(itype), .iask_n(iask_n), .ipipe_n(ipipe_n), .busy(busy));
    bcs_port u_dut (.CLK(clk), .RESET(rst), .ADDR(addr),
        .BUS_NOT_VALID_N(bnv_n), .READ_NOT_WRITE(rnw),
        .DATA_ACCESS_REQ_N(data_access_req_n_n), .DATA_SPACE_TYPE(dtype),
        .TRANSFER_OPTION_CODE(optc), .DATA_BURST_ASK_N(dask_n),
        .PIPELINED_DATA_ADDR_N(dpipe_n), .INSTR_ACCESS_REQ_N(instr_access_req_n_n),
        .INSTR_SPACE_TYPE(itype), .INSTR_BURST_ASK_N(iask_n),
        .PIPELINED_INSTR_ADDR_N(ipipe_n), .CFG_LOAD(cfg_load),
        .CFG_BASE(cfg_base), .DATA_DONE_N(dd_n), .DATA_DONE_OE_N(dd_oe_n),
        .DATA_BURST_GRANT_N(dg_n), .DATA_BURST_GRANT_OE_N(dg_oe_n),
        .INSTR_DONE_N(id_n), .INSTR_DONE_OE_N(id_oe_n),
        .INSTR_BURST_GRANT_N(ig_n), .INSTR_BURST_GRANT_OE_N(ig_oe_n),
        .PIPELINE_ACCEPT_N(pa_n), .PIPELINE_ACCEPT_OE_N(pa_oe_n),
        .RESET_CHAIN_OUT_N(rco_n), .ACC_ADDR(acc_addr), .ACC_WRITE(acc_w),
        .ACC_IS_DATA(acc_d));

    task automatic finish_test();
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [31:0] xs(logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // One access; expected words noted when it should be answered
    task automatic run(logic d, logic w, logic b, logic p, logic [2:0] o,
                       logic [1:0] s, logic bad, logic [31:0] a,
                       logic [3:0] n, logic ok);
        if (ok) begin
            for (int i = 0; i < n; i++) begin
                q.push_back({i == 0 && !p, b && i < n - 1, d, w,
                             a + 32'(i * 4)});
            end
        end
        @(posedge clk);
        go <= 1'b1;
        is_data <= d;
        cmd <= '{req: 1'b1, burst: b, pipe: p, write: w, addr: a};
        opt <= o;
        space <= s;
        bad_bus <= bad;
        words <= n;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        while (busy) @(posedge clk);
        repeat (6) @(posedge clk);
        chk("answers", 32'(q.size()), 32'h0);
    endtask

    task automatic cfg(logic [7:0] base);
        @(posedge clk);
        cfg_load <= 1'b1;
        cfg_base <= base;
        @(posedge clk);
        cfg_load <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // Compare each answered word with the oldest note
    task automatic take(logic d);
        bcs_exp_t e;
        if (q.size() == 0) begin
            chk("unexpected done", 32'h1, 32'h0);
        end else begin
            e = q.pop_front();
            chk("acc_addr", acc_addr, e.addr);
            chk("acc_is_data", 32'(acc_d), 32'(e.is_d));
            chk("acc_write", 32'(acc_w), 32'(e.wr));
            chk("done_oe", 32'(d ? dd_oe_n : id_oe_n), 32'h0);
            if (e.more) chk("grant", 32'(d ? dg_n : ig_n), 32'h0);
            if (e.first) chk("pipe_ok", 32'({pa_n, pa_oe_n}), 32'h0);
        end
    endtask

    // Watcher and hang limit
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            finish_test();
        end else if (!rst) begin
            if (dd_n === 1'b0) take(1'b1);
            if (id_n === 1'b0) take(1'b0);
        end
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Main sequence
    initial begin
        rst = 1'b1; go = 1'b0; is_data = 1'b0; bad_bus = 1'b0;
        cfg_load = 1'b0; cfg_base = 8'h00; opt = 3'h0; space = 2'h0;
        words = 4'h1; cmd = '0; rnd = 32'h6825;
        failures = 0; cmp_count = 0; cycles = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        chk("chain_out", 32'(rco_n), 32'h0);
        run(1, 0, 0, 0, 0, 0, 0, 32'hA500_0010, 1, 0);
        cfg(8'hA5);
        chk("chain_out", 32'(rco_n), 32'h1);
        for (int o = 0; o < 8; o++) begin
            run(1, o[0], 0, 0, 3'(o), 0, 0, 32'hA500_0100, 1, o < 3);
        end
        for (int s = 0; s < 4; s++) begin
            run(1, 0, 0, 0, 0, 2'(s), 0, 32'hA500_0200, 1, s == 0);
            run(0, 0, 0, 0, 0, 2'(s), 0, 32'hA500_0300, 1, s[0] == 0);
        end
        run(1, 0, 0, 0, 0, 0, 1, 32'hA500_0400, 1, 0);
        run(0, 0, 0, 0, 0, 0, 1, 32'hA500_0404, 1, 0);
        run(1, 1, 0, 0, 0, 0, 0, 32'hA600_0400, 1, 0);
        chk("oe_idle", 32'({dd_oe_n, dg_oe_n, id_oe_n, ig_oe_n, pa_oe_n}),
            32'h1F);
        for (int i = 0; i < 8; i++) begin
            rnd = xs(rnd);
            run(rnd[0], rnd[1] & rnd[0], 0, 0, rnd[3:2] % 3, 0, 0,
                {8'hA5, rnd[31:26], rnd[17:2], 2'h0}, 1, 1);
        end
        run(1, 0, 1, 0, 0, 0, 0, 32'hA500_1000, 4, 1);
        run(1, 1, 1, 0, 0, 0, 0, 32'hA500_2000, 2, 1);
        run(0, 0, 1, 0, 0, 0, 0, 32'hA500_3000, 3, 1);
        run(1, 0, 0, 1, 0, 0, 0, 32'hA500_4000, 2, 1);
        run(0, 0, 0, 1, 0, 0, 0, 32'hA500_5000, 2, 1);
        cfg(8'hFF);
        run(1, 1, 0, 0, 2, 0, 0, 32'hFF00_0008, 1, 1);
        run(1, 1, 0, 0, 2, 0, 0, 32'hA500_0008, 1, 0);
        cfg(8'h00);
        run(0, 0, 0, 0, 0, 0, 0, 32'h00FF_FFFC, 1, 1);
        // Second reset in mid-run drops the chain and the setup
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        chk("chain_out", 32'(rco_n), 32'h0);
        rst <= 1'b0;
        run(0, 0, 0, 0, 0, 0, 0, 32'h0000_0040, 1, 0);
        chk("chain_out", 32'(rco_n), 32'h0);
        finish_test();
    end
endmodule // test_bcs_port
